// [tbc_pkg.sv]
// constants and types of the trace buffer capture block
// Functional notes
// RQ1: mid alignment stores from arming, then exactly 32 lines after trigger, then disarms.
// RQ2: tagged mid trigger continues 32 lines; breakpoint only after those lines.
// RQ3: end alignment stores until final state, then disarms and stops storing.
// RQ4: end alignment never stores the flow-change event that caused the trigger.
// RQ5: four trace modes selected by the mode field.
// RQ6: flow mode stores taken-branch sources, indexed/return destinations, ordinary vectors.
// RQ7: plain branches, subroutine branch, background entry, direct jumps store nothing.
// RQ8: flow entry holds full 23-bit address plus information byte with source/destination.
// RQ9: destination stored at instruction completion even if an interrupt follows.
// RQ10: duplicate filter copies each stored address into a holding register.
// RQ11: duplicate filter drops a repeated source; destinations and vectors always stored.
// RQ12: detailed mode stores address and data of accesses, not fetch or free cycles.
// RQ13: detailed mode may limit storing to the window between comparators C and D.
// RQ14: pc mode stores every executed opcode address in flow entry format.
// RQ15: flow modes count per entry; detailed mode keeps count bit 0 clear.
// RQ16: every flow entry written has its valid bit set.
// RQ17: detailed byte access data goes to low data byte, high byte cleared.
// RQ18: detailed word access puts lower-address byte in byte3, higher in byte2.
// RQ19: line holds one detailed entry or two four-byte flow entries.
// RQ20: flow info byte: bit7 destination, bit4 valid, bits 5 and 3..0 zero.
// RQ21: flow info bit6 marks vector destination and implies destination flag.
// RQ22: detailed info byte: bit6 byte access, bit5 read access.
// RQ23: alignment field: 00 end, 01 begin, 10 mid, 11 reserved; code starts no session at 01, as at 11.
// RQ24: store is a circular 64 by 64 array; count advances after each store.
// RQ25: mode field: 00 flow, 01 duplicate filtered, 10 detailed, 11 pc.
package tbc_pkg;
    localparam int TBC_LINES = 64;
    localparam int TBC_LINE_W = 64;
    localparam int TBC_IDX_W = 6;
    localparam int TBC_CNT_W = 7;
    localparam int TBC_ADDR_W = 23;
    localparam logic [5:0] TBC_MID_LINES = 6'h20;
    localparam logic [6:0] TBC_CNT_RST = 7'h00;
    localparam logic [22:0] TBC_ADDR_RST = 23'h000000;
    localparam logic [5:0] TBC_POST_RST = 6'h00;
    localparam int TBC_INF_DEST = 7;
    localparam int TBC_INF_VEC = 6;
    localparam int TBC_INF_VALID = 4;
    localparam int TBC_INF_SIZE = 6;
    localparam int TBC_INF_READ = 5;

    typedef enum logic [1:0] {
        TBC_MODE_FLOW = 2'b00,
        TBC_MODE_DUP = 2'b01,
        TBC_MODE_DETAIL = 2'b10,
        TBC_MODE_PC = 2'b11
    } tbc_mode_t;

    typedef enum logic [1:0] {
        TBC_ALIGN_END = 2'b00,
        TBC_ALIGN_BEGIN = 2'b01,
        TBC_ALIGN_MID = 2'b10,
        TBC_ALIGN_RSVD = 2'b11
    } tbc_align_t;

    typedef enum logic [3:0] {
        TBC_FLOW_NONE = 4'h0,
        TBC_FLOW_COND_SRC = 4'h1,
        TBC_FLOW_IDX_DST = 4'h2,
        TBC_FLOW_RET_DST = 4'h3,
        TBC_FLOW_VEC = 4'h4,
        TBC_FLOW_SWI_VEC = 4'h5,
        TBC_FLOW_BGD_VEC = 4'h6,
        TBC_FLOW_UNCOND = 4'h7,
        TBC_FLOW_DIRECT = 4'h8
    } tbc_flow_t;

    typedef enum logic [1:0] {
        TBC_ST_IDLE = 2'b00,
        TBC_ST_FILL = 2'b01,
        TBC_ST_POST = 2'b10
    } tbc_state_t;

    function automatic logic [7:0] tbc_flow_info(input logic dest, input logic vec);
        logic [7:0] inf;
        inf = 8'h00;
        inf[TBC_INF_DEST] = dest | vec;
        inf[TBC_INF_VEC] = vec;
        inf[TBC_INF_VALID] = 1'b1;
        return inf;
    endfunction : tbc_flow_info
endpackage : tbc_pkg

// [tbc_line_store.sv]
// circular trace line store with half-line write enables
`timescale 1ns/1ps
module tbc_line_store
    import tbc_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // write side
    input wire logic i_wr_lo,
    input wire logic i_wr_hi,
    input wire logic [TBC_IDX_W-1:0] i_wr_line,
    input wire logic [TBC_LINE_W-1:0] i_wr_data,
    // read side
    input wire logic [TBC_IDX_W-1:0] i_rd_line,
    output logic [TBC_LINE_W-1:0] o_rd_data
);
    logic [TBC_LINE_W-1:0] mem [TBC_LINES];

    always_ff @(posedge i_clk_sys) begin
        if (i_wr_lo) begin
            mem[i_wr_line][31:0] <= i_wr_data[31:0];
        end
        if (i_wr_hi) begin
            mem[i_wr_line][63:32] <= i_wr_data[63:32];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rd_data <= 64'h0;
        end else begin
            o_rd_data <= mem[i_rd_line];
        end
    end
endmodule : tbc_line_store

// [tbc_capture.sv]
// trace buffer capture: entry selection, formatting, alignment and count
`timescale 1ns/1ps
module tbc_capture (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // control
    input wire logic i_trace_en,
    input wire logic [1:0] i_trace_mode_select,
    input wire logic [1:0] i_trigger_alignment,
    input wire logic [1:0] i_detail_range_select,
    input wire logic i_brk_en,
    input wire logic i_bgnd_active,
    // sequencer
    input wire logic i_armed,
    input wire logic i_final,
    input wire logic i_trig_on_flow,
    // flow-change events
    input wire tbc_pkg::tbc_flow_t i_flow_class,
    input wire logic [tbc_pkg::TBC_ADDR_W-1:0] i_flow_addr,
    // executed opcodes
    input wire logic i_exec_valid,
    input wire logic [tbc_pkg::TBC_ADDR_W-1:0] i_exec_pc,
    // accesses
    input wire logic i_acc_valid,
    input wire logic [tbc_pkg::TBC_ADDR_W-1:0] i_acc_addr,
    input wire logic [15:0] i_acc_data,
    input wire logic i_acc_byte,
    input wire logic i_acc_read,
    input wire logic i_acc_opfetch,
    input wire logic i_acc_free,
    // range comparators
    input wire logic [tbc_pkg::TBC_ADDR_W-1:0] i_cmp_c_addr,
    input wire logic [tbc_pkg::TBC_ADDR_W-1:0] i_cmp_d_addr,
    // readout
    input wire logic [tbc_pkg::TBC_IDX_W-1:0] i_rd_line,
    output logic [tbc_pkg::TBC_LINE_W-1:0] o_rd_data,
    // status
    output logic [tbc_pkg::TBC_CNT_W-1:0] o_trace_line_count,
    output logic o_tracing,
    output logic o_disarm,
    output logic o_brk_req
);
    import tbc_pkg::*;

    tbc_state_t state_r;
    tbc_state_t state_nxt;
    logic [TBC_CNT_W-1:0] cnt_r;
    logic [TBC_CNT_W-1:0] cnt_nxt;
    logic [5:0] post_r;
    logic [5:0] post_nxt;
    logic [TBC_ADDR_W-1:0] held_r;
    logic held_vld_r;
    logic armed_r;

    // mode decode
    wire tbc_mode_t mode = tbc_mode_t'(i_trace_mode_select);
    wire tbc_align_t align = tbc_align_t'(i_trigger_alignment);
    wire is_detail = (mode == TBC_MODE_DETAIL); // see RQ5 RQ25
    wire is_dup = (mode == TBC_MODE_DUP);
    wire is_pc = (mode == TBC_MODE_PC);
    wire is_flow = (mode == TBC_MODE_FLOW) || is_dup;
    wire align_end = (align == TBC_ALIGN_END); // see RQ23
    wire align_mid = (align == TBC_ALIGN_MID); // see RQ23
    wire arm_rise = i_armed && !armed_r;

    // storing window
    wire active = (state_r != TBC_ST_IDLE) && i_trace_en && !i_bgnd_active;

    // flow-change classification
    wire flow_src = (i_flow_class == TBC_FLOW_COND_SRC); // see RQ6
    wire flow_vec = (i_flow_class == TBC_FLOW_VEC); // see RQ6
    // completion-time destination, interrupt or not
    wire flow_dst = (i_flow_class == TBC_FLOW_IDX_DST)
                    || (i_flow_class == TBC_FLOW_RET_DST); // see RQ6 RQ9
    // uncond, direct, swi and background vectors fall through here
    wire flow_any = flow_src || flow_dst || flow_vec; // see RQ7
    wire dup_hit = is_dup && flow_src && held_vld_r && (held_r == i_flow_addr); // see RQ11
    wire trig_flow_drop = align_end && i_final && i_trig_on_flow; // see RQ4
    wire flow_take = is_flow && flow_any && !dup_hit && !trig_flow_drop;

    // pc and detailed candidates
    wire pc_take = is_pc && i_exec_valid; // see RQ14
    wire lo_ok = (i_acc_addr >= i_cmp_c_addr);
    wire hi_ok = (i_acc_addr <= i_cmp_d_addr);
    wire in_win = (i_detail_range_select == 2'b00) || (lo_ok && hi_ok); // see RQ13
    wire acc_take = is_detail && i_acc_valid && !i_acc_opfetch
                    && !i_acc_free && in_win; // see RQ12

    wire wr_en = active && (flow_take || pc_take || acc_take);

    // entry formatting
    wire [TBC_ADDR_W-1:0] ent_addr = pc_take ? i_exec_pc : i_flow_addr;
    wire [7:0] flow_info_byte = pc_take ? tbc_flow_info(1'b0, 1'b0)
                                        : tbc_flow_info(flow_dst, flow_vec); // see RQ16 RQ20 RQ21
    wire [31:0] flow_entry = {flow_info_byte, 1'b0, ent_addr}; // see RQ8
    wire [7:0] detail_info_byte = {1'b0, i_acc_byte, i_acc_read, 5'h00}; // see RQ22
    wire [7:0] trace_data_high = i_acc_byte ? 8'h00 : i_acc_data[15:8]; // see RQ17
    wire [7:0] trace_data_low = i_acc_data[7:0]; // see RQ18
    wire [63:0] detail_line = {detail_info_byte, 1'b0, i_acc_addr,
                               trace_data_high, trace_data_low, 16'h0000}; // see RQ19
    wire [63:0] wr_data = is_detail ? detail_line : {flow_entry, flow_entry}; // see RQ19
    wire wr_lo = wr_en && (is_detail || !cnt_r[0]);
    wire wr_hi = wr_en && (is_detail || cnt_r[0]);
    wire line_done = wr_en && (is_detail || cnt_r[0]);

    // count advance
    wire [5:0] line_inc = cnt_r[6:1] + 6'h01;
    always_comb begin
        cnt_nxt = cnt_r;
        if (wr_en && is_detail) begin
            cnt_nxt = {line_inc, 1'b0}; // see RQ15
        end else if (wr_en) begin
            cnt_nxt = cnt_r + 7'h01; // see RQ15
        end
    end

    // session end
    wire end_hit = (state_r == TBC_ST_FILL) && align_end && i_final; // see RQ3
    wire post_done = (state_r == TBC_ST_POST) && line_done
                     && (post_r == TBC_MID_LINES - 6'h01); // see RQ1

    always_comb begin
        state_nxt = state_r;
        post_nxt = post_r;
        unique case (state_r)
            TBC_ST_IDLE: begin
                if (arm_rise && i_trace_en && (align_end || align_mid)) begin
                    state_nxt = TBC_ST_FILL; // see RQ1
                end
            end
            TBC_ST_FILL: begin
                if (!i_armed || end_hit) begin
                    state_nxt = TBC_ST_IDLE;
                end else if (align_mid && i_final) begin
                    state_nxt = TBC_ST_POST; // see RQ2
                    post_nxt = TBC_POST_RST;
                end
            end
            TBC_ST_POST: begin
                if (!i_armed || post_done) begin
                    state_nxt = TBC_ST_IDLE;
                end else if (line_done) begin
                    post_nxt = post_r + 6'h01;
                end
            end
            default: begin
                state_nxt = TBC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= TBC_ST_IDLE;
            post_r <= TBC_POST_RST;
            cnt_r <= TBC_CNT_RST;
            armed_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            post_r <= post_nxt;
            cnt_r <= cnt_nxt; // see RQ24
            armed_r <= i_armed;
        end
    end

    // holding register for the duplicate filter
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            held_r <= TBC_ADDR_RST;
            held_vld_r <= 1'b0;
        end else if (state_r == TBC_ST_IDLE) begin
            held_vld_r <= 1'b0;
        end else if (wr_en && !is_detail) begin
            held_r <= ent_addr; // see RQ10
            held_vld_r <= 1'b1;
        end
    end

    tbc_line_store u_store (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_wr_lo(wr_lo),
        .i_wr_hi(wr_hi),
        .i_wr_line(cnt_r[6:1]), // see RQ24
        .i_wr_data(wr_data),
        .i_rd_line(i_rd_line),
        .o_rd_data(o_rd_data)
    );

    assign o_trace_line_count = cnt_r;
    assign o_tracing = (state_r != TBC_ST_IDLE);
    assign o_disarm = end_hit || post_done; // see RQ3
    assign o_brk_req = i_brk_en && (end_hit || post_done); // see RQ2

    // checks
    sequence s_mid_trig;
        (state_r == TBC_ST_FILL) && align_mid && i_final && i_armed;
    endsequence

    sequence s_post_entry;
        ##1 (state_r == TBC_ST_POST) && (post_r == TBC_POST_RST);
    endsequence

    a_mid_post_entry: assert property ( // see RQ1
        @(posedge i_clk_sys) disable iff (!i_nrst)
        s_mid_trig |-> s_post_entry
    ) else $error("mid trigger did not start post count");

    a_post_limit: assert property ( // see RQ1
        @(posedge i_clk_sys) disable iff (!i_nrst)
        post_done |-> (post_r == 6'h1f) ##1 (state_r == TBC_ST_IDLE) && !o_tracing
    ) else $error("post trigger line count wrong");

    a_brk_after_lines: assert property ( // see RQ2
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (o_brk_req && align_mid) |-> (state_r == TBC_ST_POST) && line_done
    ) else $error("mid breakpoint before lines stored");

    a_end_stops: assert property ( // see RQ3
        @(posedge i_clk_sys) disable iff (!i_nrst)
        end_hit |-> o_disarm ##1 (state_r == TBC_ST_IDLE) ##1 !wr_en
    ) else $error("end alignment kept storing");

    a_trig_flow_drop: assert property ( // see RQ4
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (end_hit && i_trig_on_flow && !is_detail && !is_pc) |-> !wr_en
    ) else $error("trigger flow event stored");

    a_skip_plain: assert property ( // see RQ7
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (is_flow && ((i_flow_class == TBC_FLOW_UNCOND)
         || (i_flow_class == TBC_FLOW_DIRECT)
         || (i_flow_class == TBC_FLOW_SWI_VEC)
         || (i_flow_class == TBC_FLOW_BGD_VEC))) |-> !wr_en
    ) else $error("non flow event stored");

    a_dup_filter: assert property ( // see RQ11
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (wr_en && is_dup && flow_src)
        |=> !(is_dup && flow_src && i_flow_addr == $past(i_flow_addr)
              && $stable(i_trace_mode_select) && wr_en)
    ) else $error("duplicate source stored");

    a_fetch_skip: assert property ( // see RQ12
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (is_detail && (i_acc_opfetch || i_acc_free)) |-> !wr_en
    ) else $error("fetch or free cycle stored");

    a_cnt_flow: assert property ( // see RQ15
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (wr_en && !is_detail) |=> (cnt_r == $past(cnt_r) + 7'h01)
    ) else $error("flow count step wrong");

    a_cnt_detail: assert property ( // see RQ15
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (wr_en && is_detail) |=> !cnt_r[0] && (cnt_r[6:1] == $past(cnt_r[6:1]) + 6'h01)
    ) else $error("detail count step wrong");

    a_flow_info: assert property ( // see RQ20 RQ21
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (wr_en && !is_detail) |-> wr_data[60] && !wr_data[61] && (wr_data[59:56] == 4'h0)
                                 && (!wr_data[62] || wr_data[63])
    ) else $error("flow info byte malformed");

    a_byte_data: assert property ( // see RQ17
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (wr_en && is_detail && i_acc_byte) |-> (wr_data[31:24] == 8'h00) && wr_data[62]
    ) else $error("byte access data misplaced");
endmodule : tbc_capture

// [tbc_seq_model.sv]
// sequencer partner model: arm level and final-state indication
`timescale 1ns/1ps
module tbc_seq_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // bench requests
    input wire logic i_go,
    input wire logic i_trig,
    input wire logic i_disarm,
    // to capture block
    output logic o_armed,
    output logic o_final
);
    assign o_final = i_trig & o_armed;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_armed <= 1'b0;
        end else if (i_go) begin
            o_armed <= 1'b1;
        end else if (i_disarm) begin
            o_armed <= 1'b0;
        end
    end
endmodule : tbc_seq_model

// [tbc_capture_bench.sv]
// self-checking bench of the trace capture block
`timescale 1ns/1ps
module tbc_capture_bench;
    import tbc_pkg::*;
    typedef struct packed {
        logic [1:0] md;
        tbc_flow_t cl;
        logic [22:0] ad;
        logic [15:0] dt;
        logic [3:0] fl;
        logic [1:0] rg;
        logic [6:0] cn;
        logic [63:0] ln;
    } tbc_row_t;
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic en = 1'b1, brk = 1'b0, bgnd = 1'b0, trig = 1'b0, tcof = 1'b0, go = 1'b0;
    logic [1:0] md = 2'h0, al = 2'h0, rg = 2'h0;
    tbc_flow_t cl = TBC_FLOW_NONE;
    logic [22:0] cad = 23'h0, xpc = 23'h0, aad = 23'h0;
    logic [15:0] adt = 16'h0;
    logic xv = 1'b0, av = 1'b0, ab = 1'b0, ar = 1'b0, aop = 1'b0, afr = 1'b0;
    logic [5:0] rl = 6'h0;
    logic [63:0] rd;
    logic [6:0] cnt;
    logic trc, dis, brq, armed, fin;
    int err_total = 0, n_tests = 0, k;
    tbc_row_t rows [17];

    always #20 i_clk_sys = ~i_clk_sys;

    tbc_seq_model i_tbc_seq_model (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_go(go),
        .i_trig(trig), .i_disarm(dis), .o_armed(armed), .o_final(fin));
    tbc_capture i_tbc_capture (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_trace_en(en),
        .i_trace_mode_select(md), .i_trigger_alignment(al), .i_detail_range_select(rg),
        .i_brk_en(brk), .i_bgnd_active(bgnd), .i_armed(armed), .i_final(fin),
        .i_trig_on_flow(tcof), .i_flow_class(cl), .i_flow_addr(cad), .i_exec_valid(xv),
        .i_exec_pc(xpc), .i_acc_valid(av), .i_acc_addr(aad), .i_acc_data(adt),
        .i_acc_byte(ab), .i_acc_read(ar), .i_acc_opfetch(aop), .i_acc_free(afr),
        .i_cmp_c_addr(23'h001000), .i_cmp_d_addr(23'h001fff), .i_rd_line(rl),
        .o_rd_data(rd), .o_trace_line_count(cnt), .o_tracing(trc), .o_disarm(dis),
        .o_brk_req(brq));

    function automatic logic [63:0] fe(input logic [7:0] i, input logic [22:0] a);
        return {32'h0, i, 1'b0, a};
    endfunction : fe
    function automatic logic [63:0] de(input logic [7:0] i, input logic [22:0] a,
                                       input logic [15:0] b);
        return {i, 1'b0, a, b, 16'h0};
    endfunction : de
    task automatic clkn(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask : clkn
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (!ok) begin
            err_total++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    task automatic rst(input int n);
        i_nrst = 1'b0;
        clkn(n);
        i_nrst = 1'b1;
        clkn(1);
    endtask : rst
    task automatic arm(input logic [1:0] m, input logic [1:0] a);
        md = m;
        al = a;
        go = 1'b1;
        clkn(1);
        go = 1'b0;
        clkn(1);
    endtask : arm
    task automatic ev(input tbc_flow_t c, input logic [22:0] a, input logic [15:0] d,
                      input logic [3:0] f);
        cl = c;
        cad = a;
        xpc = a;
        aad = a;
        adt = d;
        {ab, ar, aop, afr} = f;
        xv = 1'b1;
        av = 1'b1;
        clkn(1);
        cl = TBC_FLOW_NONE;
        xv = 1'b0;
        av = 1'b0;
    endtask : ev

    initial begin
        rows[0] = '{2'h0, TBC_FLOW_COND_SRC, 23'h012345, 16'h0, 4'h0, 2'h0,
            7'h01, fe(8'h10, 23'h012345)};
        rows[1] = '{2'h0, TBC_FLOW_IDX_DST, 23'h054321, 16'h0, 4'h0, 2'h0,
            7'h01, fe(8'h90, 23'h054321)};
        rows[2] = '{2'h0, TBC_FLOW_RET_DST, 23'h7fffff, 16'h0, 4'h0, 2'h0,
            7'h01, fe(8'h90, 23'h7fffff)};
        rows[3] = '{2'h0, TBC_FLOW_VEC, 23'h00fff2, 16'h0, 4'h0, 2'h0,
            7'h01, fe(8'hd0, 23'h00fff2)};
        rows[4] = '{2'h0, TBC_FLOW_SWI_VEC, 23'h00fff6, 16'h0, 4'h0, 2'h0, 7'h00, 64'h0};
        rows[5] = '{2'h0, TBC_FLOW_BGD_VEC, 23'h00fff4, 16'h0, 4'h0, 2'h0, 7'h00, 64'h0};
        rows[6] = '{2'h0, TBC_FLOW_UNCOND, 23'h000010, 16'h0, 4'h0, 2'h0, 7'h00, 64'h0};
        rows[7] = '{2'h0, TBC_FLOW_DIRECT, 23'h000020, 16'h0, 4'h0, 2'h0, 7'h00, 64'h0};
        rows[8] = '{2'h3, TBC_FLOW_NONE, 23'h7ffffe, 16'h0, 4'h0, 2'h0,
            7'h01, fe(8'h10, 23'h7ffffe)};
        rows[9] = '{2'h2, TBC_FLOW_NONE, 23'h001234, 16'habcd, 4'h4, 2'h0,
            7'h02, de(8'h20, 23'h001234, 16'habcd)};
        rows[10] = '{2'h2, TBC_FLOW_NONE, 23'h004321, 16'h5a7e, 4'h8, 2'h0,
            7'h02, de(8'h40, 23'h004321, 16'h007e)};
        rows[11] = '{2'h2, TBC_FLOW_NONE, 23'h001234, 16'h1111, 4'h2, 2'h0, 7'h00, 64'h0};
        rows[12] = '{2'h2, TBC_FLOW_NONE, 23'h001234, 16'h2222, 4'h1, 2'h0, 7'h00, 64'h0};
        rows[13] = '{2'h2, TBC_FLOW_NONE, 23'h001000, 16'h1122, 4'h0, 2'h1,
            7'h02, de(8'h00, 23'h001000, 16'h1122)};
        rows[14] = '{2'h2, TBC_FLOW_NONE, 23'h002000, 16'h3344, 4'h0, 2'h3, 7'h00, 64'h0};
        rows[15] = '{2'h2, TBC_FLOW_NONE, 23'h001fff, 16'h0033, 4'hc, 2'h2,
            7'h02, de(8'h60, 23'h001fff, 16'h0033)};
        rows[16] = '{2'h1, TBC_FLOW_COND_SRC, 23'h000002, 16'h0, 4'h0, 2'h0,
            7'h01, fe(8'h10, 23'h000002)};
        clkn(8);
        chk(cnt === 7'h00 && trc === 1'b0 && dis === 1'b0 && brq === 1'b0
            && rd === 64'h0, "reset values");
        i_nrst = 1'b1;
        clkn(1);
        for (int i = 0; i < 17; i++) begin
            rst(2);
            rg = rows[i].rg;
            arm(rows[i].md, 2'h0);
            chk(trc === 1'b1, "not tracing after arm");
            ev(rows[i].cl, rows[i].ad, rows[i].dt, rows[i].fl);
            trig = 1'b1;
            #1;
            chk(dis === 1'b1 && brq === 1'b0, "end trigger");
            clkn(1);
            trig = 1'b0;
            chk(cnt === rows[i].cn, "entry count");
            rl = 6'h00;
            clkn(1);
            chk((rows[i].md == 2'h2 ? rd : {32'h0, rd[31:0]}) === rows[i].ln || rows[i].cn == 7'h0,
                "line content");
        end
        rst(2);
        rg = 2'h0;
        arm(2'h0, 2'h0);
        ev(TBC_FLOW_COND_SRC, 23'h000100, 16'h0, 4'h0);
        bgnd = 1'b1;
        ev(TBC_FLOW_COND_SRC, 23'h000104, 16'h0, 4'h0);
        bgnd = 1'b0;
        trig = 1'b1;
        tcof = 1'b1;
        ev(TBC_FLOW_COND_SRC, 23'h000108, 16'h0, 4'h0);
        trig = 1'b0;
        tcof = 1'b0;
        ev(TBC_FLOW_IDX_DST, 23'h00010c, 16'h0, 4'h0);
        chk(cnt === 7'h01 && trc === 1'b0,
            "end trigger event or later entry stored");
        rst(2);
        arm(2'h1, 2'h0);
        ev(TBC_FLOW_COND_SRC, 23'h000200, 16'h0, 4'h0);
        ev(TBC_FLOW_COND_SRC, 23'h000200, 16'h0, 4'h0);
        ev(TBC_FLOW_IDX_DST, 23'h000300, 16'h0, 4'h0);
        ev(TBC_FLOW_IDX_DST, 23'h000300, 16'h0, 4'h0);
        ev(TBC_FLOW_COND_SRC, 23'h000200, 16'h0, 4'h0);
        chk(cnt === 7'h04, "duplicate filter count");
        rl = 6'h00;
        clkn(1);
        chk(rd === {8'h90, 1'b0, 23'h000300, 8'h10, 1'b0, 23'h000200}, "line 0");
        rl = 6'h01;
        clkn(1);
        chk(rd === {8'h10, 1'b0, 23'h000200, 8'h90, 1'b0, 23'h000300}, "line 1");
        rst(2);
        brk = 1'b1;
        arm(2'h3, 2'h2);
        xv = 1'b1;
        clkn(3);
        trig = 1'b1;
        clkn(1);
        trig = 1'b0;
        for (k = 1; k <= 100; k++) begin
            #1;
            if (dis === 1'b1) break;
            clkn(1);
        end
        if (k > 100) begin
            err_total++;
        end
        chk(k == 64 && brq === 1'b1, "mid session length or break request");
        clkn(3);
        chk(cnt === 7'h44 && trc === 1'b0, "stored after mid end");
        xv = 1'b0;
        for (int i = 0; i < 3; i++) begin
            rst(2);
            en = (i < 2);
            arm(2'h0, i == 0 ? 2'h1 : (i == 1 ? 2'h3 : 2'h0));
            chk(trc === 1'b0, "session started when refused");
        end
        give_verdict();
    end
endmodule : tbc_capture_bench
